// ### src/ddra_defs.vh
// constants for the dual-rank command and address decoder
`ifndef DDRA_DEFS_VH
`define DDRA_DEFS_VH

`define DDRA_RANKS        2
`define DDRA_BANKS        8
`define DDRA_ROW_W        15
`define DDRA_ADDR_W       15
`define DDRA_BA_W         3
`define DDRA_MR_W         16
`define DDRA_COL_W        11
`define DDRA_AP_BIT       10
`define DDRA_BC_BIT       12
`define DDRA_COL_HI_BIT   11
`define DDRA_MR_COUNT     4
// mode register zero: 2-bit burst field, 2'b01 = on-the-fly chop
`define DDRA_MR0_BL_LSB   0
`define DDRA_BL_OTF       2'h1
`define DDRA_BL_FIX4      2'h2
`define DDRA_MR0_RESET    16'h0000
// {ras_n,cas_n,we_n}
`define DDRA_CMD_MRS      3'h0
`define DDRA_CMD_REF      3'h1
`define DDRA_CMD_PRE      3'h2
`define DDRA_CMD_ACT      3'h3
`define DDRA_CMD_WR       3'h4
`define DDRA_CMD_RD       3'h5
`define DDRA_CMD_ZQ       3'h6
`define DDRA_CMD_NOP      3'h7
`define DDRA_BURST_8      4'h8
`define DDRA_BURST_4      4'h4
`define DDRA_BURST_NONE   4'h0
// output event codes
`define DDRA_EV_NONE      3'h0
`define DDRA_EV_ACT       3'h1
`define DDRA_EV_RD        3'h2
`define DDRA_EV_WR        3'h3
`define DDRA_EV_PRE       3'h4
`define DDRA_EV_PREA      3'h5
`define DDRA_EV_MRS       3'h6
`define DDRA_EV_REF       3'h7

`endif

// ### src/ddra_rank.v
// one rank: command decode, bank row tracking and mode registers
`timescale 1ns/1ps
`include "ddra_defs.vh"
module ddra_rank
(
  // clock and reset
  input  wire                        ref_clk,
  input  wire                        reset_n,
  // registered pins and the unregistered by-8 setting
  input  wire                        cs_n,
  input  wire [2:0]                  cmd,
  input  wire [`DDRA_BA_W-1:0]       ba,
  input  wire [`DDRA_ADDR_W-1:0]     addr,
  input  wire                        x8_mode,
  // decoded results
  output reg  [2:0]                  ev_reg,
  output reg  [`DDRA_BA_W-1:0]       bank_reg,
  output reg  [`DDRA_ROW_W-1:0]      row_reg,
  output reg  [`DDRA_COL_W-1:0]      col_reg,
  output reg                         ap_reg,
  output reg  [3:0]                  burst_reg,
  output reg  [`DDRA_BANKS-1:0]      open_reg,
  output reg  [`DDRA_MR_W-1:0]       mr0_reg
);

  reg  [`DDRA_ROW_W-1:0] rows_reg [0:`DDRA_BANKS-1];
  reg  [`DDRA_MR_W-1:0]  mr_reg   [1:`DDRA_MR_COUNT-1];
  wire                   hit;
  wire [1:0]             bl_field;
  wire [`DDRA_COL_W-1:0] col_dec;
  wire [3:0]             burst_dec;
  reg  [2:0]             ev_next;

  assign hit = ~cs_n;
  assign bl_field = mr0_reg[`DDRA_MR0_BL_LSB+1:`DDRA_MR0_BL_LSB];
  // by-8 ignores bit 11
  assign col_dec = x8_mode ? {1'b0, addr[9:0]} :
                   {addr[`DDRA_COL_HI_BIT], addr[9:0]};
  assign burst_dec = (bl_field == `DDRA_BL_OTF) ?
                     (addr[`DDRA_BC_BIT] ? `DDRA_BURST_8 : `DDRA_BURST_4) :
                     ((bl_field == `DDRA_BL_FIX4) ? `DDRA_BURST_4 : `DDRA_BURST_8);

  always @*
  begin
    ev_next = `DDRA_EV_NONE;
    if (hit)
    begin
      case (cmd)
        `DDRA_CMD_ACT: ev_next = `DDRA_EV_ACT;
        `DDRA_CMD_RD:  ev_next = `DDRA_EV_RD;
        `DDRA_CMD_WR:  ev_next = `DDRA_EV_WR;
        `DDRA_CMD_PRE: ev_next = addr[`DDRA_AP_BIT] ? `DDRA_EV_PREA : `DDRA_EV_PRE;
        `DDRA_CMD_MRS: ev_next = `DDRA_EV_MRS;
        `DDRA_CMD_REF: ev_next = `DDRA_EV_REF;
        default:       ev_next = `DDRA_EV_NONE;
      endcase
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < `DDRA_BANKS; gb = gb + 1)
    begin : g_bank
      // each bank keeps its own row, so banks stay open together
      always @(posedge ref_clk)
      begin
        if (!reset_n)
        begin
          open_reg[gb] <= 1'b0;
          rows_reg[gb] <= {`DDRA_ROW_W{1'b0}};
        end
        else if (ba == gb)
        begin
          if (ev_next == `DDRA_EV_ACT)
          begin
            open_reg[gb] <= 1'b1;
            rows_reg[gb] <= addr[`DDRA_ROW_W-1:0];
          end
          else if (ev_next == `DDRA_EV_PRE || ev_next == `DDRA_EV_PREA)
            open_reg[gb] <= 1'b0;
          // auto precharge modelled as closing at command time
          else if ((ev_next == `DDRA_EV_RD || ev_next == `DDRA_EV_WR) && addr[`DDRA_AP_BIT])
            open_reg[gb] <= 1'b0;
        end
        else if (ev_next == `DDRA_EV_PREA)
          open_reg[gb] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      ev_reg    <= `DDRA_EV_NONE;
      bank_reg  <= {`DDRA_BA_W{1'b0}};
      row_reg   <= {`DDRA_ROW_W{1'b0}};
      col_reg   <= {`DDRA_COL_W{1'b0}};
      ap_reg    <= 1'b0;
      burst_reg <= `DDRA_BURST_NONE;
      mr0_reg   <= `DDRA_MR0_RESET;
      mr_reg[1] <= `DDRA_MR0_RESET;
      mr_reg[2] <= `DDRA_MR0_RESET;
      mr_reg[3] <= `DDRA_MR0_RESET;
    end
    else
    begin
      ev_reg    <= ev_next;
      bank_reg  <= ba;
      row_reg   <= (ev_next == `DDRA_EV_ACT) ? addr : rows_reg[ba];
      col_reg   <= col_dec;
      ap_reg    <= addr[`DDRA_AP_BIT] & (ev_next == `DDRA_EV_RD || ev_next == `DDRA_EV_WR);
      burst_reg <= (ev_next == `DDRA_EV_RD || ev_next == `DDRA_EV_WR) ? burst_dec : `DDRA_BURST_NONE;
      // bank bit 2 must be zero for a mode load; higher codes are dropped
      if (ev_next == `DDRA_EV_MRS && !ba[2])
      begin
        case (ba[1:0])
          2'h0:    mr0_reg   <= {1'b0, addr};
          2'h1:    mr_reg[1] <= {1'b0, addr};
          2'h2:    mr_reg[2] <= {1'b0, addr};
          default: mr_reg[3] <= {1'b0, addr};
        endcase
      end
    end
  end

endmodule

// ### src/ddra_top.v
// dual-rank command and address decoder top
`timescale 1ns/1ps
`include "ddra_defs.vh"
module ddra_top
(
  // clock and reset
  input  wire                         ref_clk,
  input  wire                         reset_n,
  // command pins, all ranks
  input  wire [`DDRA_RANKS-1:0]       cs_n_pin,
  input  wire [`DDRA_RANKS-1:0]       cke_pin,
  input  wire [`DDRA_RANKS-1:0]       termination_control,
  input  wire                         ras_n_pin,
  input  wire                         cas_n_pin,
  input  wire                         we_n_pin,
  input  wire [`DDRA_BA_W-1:0]        ba_pin,
  input  wire [`DDRA_ADDR_W-1:0]      addr_pin,
  // configuration
  input  wire                         x8_mode,
  // per-rank decoded outputs, rank 1 in upper slice
  output reg  [`DDRA_RANKS*3-1:0]             ev_out,
  output reg  [`DDRA_RANKS*`DDRA_BA_W-1:0]    bank_out,
  output reg  [`DDRA_RANKS*`DDRA_ROW_W-1:0]   row_out,
  output reg  [`DDRA_RANKS*`DDRA_COL_W-1:0]   col_out,
  output reg  [`DDRA_RANKS-1:0]               auto_precharge_addr_bit,
  output reg  [`DDRA_RANKS*4-1:0]             burst_length,
  output reg  [`DDRA_RANKS*`DDRA_BANKS-1:0]   open_banks,
  output reg  [`DDRA_RANKS*`DDRA_MR_W-1:0]    mode_register_zero,
  output reg  [`DDRA_RANKS-1:0]               termination_on
);

  // all pins pass the same register stage so they stay aligned
  reg  [`DDRA_RANKS-1:0]   cs_n_reg;
  reg  [`DDRA_RANKS-1:0]   cke_reg;
  reg  [`DDRA_RANKS-1:0]   odt_reg;
  reg  [2:0]               cmd_reg;
  reg  [`DDRA_BA_W-1:0]    ba_reg;
  reg  [`DDRA_ADDR_W-1:0]  addr_reg;

  wire [`DDRA_RANKS*3-1:0]            ev_w;
  wire [`DDRA_RANKS*`DDRA_BA_W-1:0]   bank_w;
  wire [`DDRA_RANKS*`DDRA_ROW_W-1:0]  row_w;
  wire [`DDRA_RANKS*`DDRA_COL_W-1:0]  col_w;
  wire [`DDRA_RANKS-1:0]              ap_w;
  wire [`DDRA_RANKS*4-1:0]            burst_w;
  wire [`DDRA_RANKS*`DDRA_BANKS-1:0]  open_w;
  wire [`DDRA_RANKS*`DDRA_MR_W-1:0]   mr0_w;

  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      cs_n_reg <= {`DDRA_RANKS{1'b1}};
      cke_reg  <= {`DDRA_RANKS{1'b0}};
      odt_reg  <= {`DDRA_RANKS{1'b0}};
      cmd_reg  <= `DDRA_CMD_NOP;
      ba_reg   <= {`DDRA_BA_W{1'b0}};
      addr_reg <= {`DDRA_ADDR_W{1'b0}};
    end
    else
    begin
      cs_n_reg <= cs_n_pin;
      cke_reg  <= cke_pin;
      odt_reg  <= termination_control;
      cmd_reg  <= {ras_n_pin, cas_n_pin, we_n_pin};
      ba_reg   <= ba_pin;
      addr_reg <= addr_pin;
    end
  end

  genvar gr;
  generate
    for (gr = 0; gr < `DDRA_RANKS; gr = gr + 1)
    begin : g_rank
      // a rank with its clock gate low sees chip select high
      ddra_rank u_rank
      (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .cs_n      (cs_n_reg[gr] | ~cke_reg[gr]),
        .cmd       (cmd_reg),
        .ba        (ba_reg),
        .addr      (addr_reg),
        .x8_mode   (x8_mode),
        .ev_reg    (ev_w[gr*3 +: 3]),
        .bank_reg  (bank_w[gr*`DDRA_BA_W +: `DDRA_BA_W]),
        .row_reg   (row_w[gr*`DDRA_ROW_W +: `DDRA_ROW_W]),
        .col_reg   (col_w[gr*`DDRA_COL_W +: `DDRA_COL_W]),
        .ap_reg    (ap_w[gr]),
        .burst_reg (burst_w[gr*4 +: 4]),
        .open_reg  (open_w[gr*`DDRA_BANKS +: `DDRA_BANKS]),
        .mr0_reg   (mr0_w[gr*`DDRA_MR_W +: `DDRA_MR_W])
      );
    end
  endgenerate

  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      ev_out                  <= {`DDRA_RANKS*3{1'b0}};
      bank_out                <= {`DDRA_RANKS*`DDRA_BA_W{1'b0}};
      row_out                 <= {`DDRA_RANKS*`DDRA_ROW_W{1'b0}};
      col_out                 <= {`DDRA_RANKS*`DDRA_COL_W{1'b0}};
      auto_precharge_addr_bit <= {`DDRA_RANKS{1'b0}};
      burst_length            <= {`DDRA_RANKS*4{1'b0}};
      open_banks              <= {`DDRA_RANKS*`DDRA_BANKS{1'b0}};
      mode_register_zero      <= {`DDRA_RANKS*`DDRA_MR_W{1'b0}};
      termination_on          <= {`DDRA_RANKS{1'b0}};
    end
    else
    begin
      ev_out                  <= ev_w;
      bank_out                <= bank_w;
      row_out                 <= row_w;
      col_out                 <= col_w;
      auto_precharge_addr_bit <= ap_w;
      burst_length            <= burst_w;
      open_banks              <= open_w;
      mode_register_zero      <= mr0_w;
      termination_on          <= odt_reg;
    end
  end

endmodule

// ### tb/ddra_chk_monitor.sv
// concurrent checks on the decoder top ports
`timescale 1ns/1ps
`include "ddra_defs.vh"
module ddra_chk
(
  // clock and reset
  input logic        ref_clk,
  input logic        reset_n,
  // pins
  input logic [1:0]  cs_n_pin,
  input logic [1:0]  cke_pin,
  input logic        ras_n_pin,
  input logic        cas_n_pin,
  input logic        we_n_pin,
  input logic [2:0]  ba_pin,
  input logic [14:0] addr_pin,
  input logic        x8_mode,
  // results
  input logic [5:0]  ev_out,
  input logic [5:0]  bank_out,
  input logic [29:0] row_out,
  input logic [21:0] col_out,
  input logic [1:0]  auto_precharge_addr_bit,
  input logic [7:0]  burst_length,
  input logic [15:0] open_banks,
  input logic [31:0] mode_register_zero,
  // termination request and its registered copy
  input logic [1:0]  termination_control,
  input logic [1:0]  termination_on
);
  wire [2:0] c  = {ras_n_pin, cas_n_pin, we_n_pin};
  wire       s0 = !cs_n_pin[0] && cke_pin[0];
  wire       rw = s0 && (c == `DDRA_CMD_RD || c == `DDRA_CMD_WR);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // three register stages between pins and decoded outputs, two for termination_on
  cs_mask_a: assert property (ev_out[2:0] != 0 |-> $past(s0, 3))
    else $error("rank 0 event unselected");
  rank_one_a: assert property (ev_out[5:3] != 0 |-> $past(!cs_n_pin[1] && cke_pin[1], 3))
    else $error("rank 1 event unselected");
  act_row_a: assert property ($past(s0 && c == `DDRA_CMD_ACT, 3) |->
    ev_out[2:0] == `DDRA_EV_ACT && row_out[14:0] == $past(addr_pin, 3) && open_banks[$past(ba_pin, 3)])
    else $error("activate decode");
  bank_sel_a: assert property ($past(rw, 3) |-> bank_out[2:0] == $past(ba_pin, 3))
    else $error("bank select");
  rd_col_a: assert property ($past(rw && !x8_mode, 3) |->
    col_out[10:0] == {$past(addr_pin[11], 3), $past(addr_pin[9:0], 3)}) else $error("column");
  col_x8_a: assert property ($past(rw && x8_mode, 3) |-> col_out[10:0] == {1'b0, $past(addr_pin[9:0], 3)})
    else $error("by-8 column");
  term_pass_a: assert property (termination_on == $past(termination_control, 2))
    else $error("termination pass-through");
  ap_bit_a: assert property ($past(rw, 3) |-> auto_precharge_addr_bit[0] == $past(addr_pin[10], 3))
    else $error("auto precharge");
  pre_all_a: assert property ($past(s0 && c == `DDRA_CMD_PRE && addr_pin[10], 3) |->
    ev_out[2:0] == `DDRA_EV_PREA && open_banks[7:0] == 0) else $error("precharge all");
  mr_load_a: assert property ($past(s0 && c == `DDRA_CMD_MRS && ba_pin == 0, 3) |->
    mode_register_zero[15:0] == {1'b0, $past(addr_pin, 3)}) else $error("mode load");
  chop_sel_a: assert property ($past(rw, 3) && mode_register_zero[1:0] == `DDRA_BL_OTF
    && $stable(mode_register_zero) |-> burst_length[3:0] == ($past(addr_pin[12], 3) ? 4'h8 : 4'h4))
    else $error("burst chop");
endmodule

// ### tb/ddra_ctl_model.sv
// behavioural memory controller driving the command pins
`timescale 1ns/1ps
`include "ddra_defs.vh"
module ddra_ctl_model
(
  // clock
  input  logic        ref_clk,
  // command pins
  output logic [1:0]  cs_n_pin,
  output logic [1:0]  cke_pin,
  output logic [1:0]  termination_control,
  output logic        ras_n_pin,
  output logic        cas_n_pin,
  output logic        we_n_pin,
  output logic [2:0]  ba_pin,
  output logic [14:0] addr_pin
);
  initial {cs_n_pin, cke_pin, termination_control} = 6'h3C;
  initial {ras_n_pin, cas_n_pin, we_n_pin, ba_pin, addr_pin} = 21'h1C0000;
  // called at a falling edge, so exactly one rising edge sees the command
  task issue(input logic [1:0] cs, input logic [1:0] ck, input logic [2:0] cm, input logic [2:0] b,
             input logic [14:0] a);
    {cs_n_pin, cke_pin, termination_control} = {cs, ck, a[1:0]};
    {ras_n_pin, cas_n_pin, we_n_pin, ba_pin, addr_pin} = {cm, b, a};
    @(negedge ref_clk);
    // released bank and address lines show the inverse so a stale value never looks valid
    {cs_n_pin, cke_pin} = 4'hF;
    {ras_n_pin, cas_n_pin, we_n_pin, ba_pin, addr_pin} = {`DDRA_CMD_NOP, ~b, ~a};
  endtask
endmodule

// ### tb/ddr3l_dual_rank_addressing_tb.sv
// self-checking bench for the dual-rank decoder
`timescale 1ns/1ps
`include "ddra_defs.vh"
module ddr3l_dual_rank_addressing_tb;
  logic        ref_clk = 0;
  logic        reset_n = 0;
  logic        x8_mode = 0;
  wire  [1:0]  cs_n_pin, cke_pin, termination_control, auto_precharge_addr_bit, termination_on;
  wire         ras_n_pin, cas_n_pin, we_n_pin;
  wire  [2:0]  ba_pin;
  wire  [14:0] addr_pin;
  wire  [5:0]  ev_out, bank_out;
  wire  [29:0] row_out;
  wire  [21:0] col_out;
  wire  [7:0]  burst_length;
  wire  [15:0] open_banks;
  wire  [31:0] mode_register_zero;
  logic [7:0]  open_exp [2] = '{8'h00, 8'h00};
  logic [15:0] mr_exp [2] = '{16'h0000, 16'h0000};
  int          mismatches = 0;
  int          samples_checked = 0;
  always #2 ref_clk = ~ref_clk;
  ddra_ctl_model u_ddra_ctl_model (.ref_clk, .cs_n_pin, .cke_pin, .termination_control, .ras_n_pin, .cas_n_pin,
    .we_n_pin, .ba_pin, .addr_pin);
  ddra_top u_ddra_top (.ref_clk, .reset_n, .cs_n_pin, .cke_pin, .termination_control, .ras_n_pin, .cas_n_pin,
    .we_n_pin, .ba_pin, .addr_pin, .x8_mode, .ev_out, .bank_out, .row_out, .col_out, .auto_precharge_addr_bit,
    .burst_length, .open_banks, .mode_register_zero, .termination_on);
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  function automatic logic [2:0] ev_of(input logic [2:0] cm, input logic a10);
    logic [2:0] t [8] = '{`DDRA_EV_MRS, `DDRA_EV_REF, `DDRA_EV_PRE, `DDRA_EV_ACT, `DDRA_EV_WR, `DDRA_EV_RD,
      `DDRA_EV_NONE, `DDRA_EV_NONE};
    ev_of = (cm == `DDRA_CMD_PRE && a10) ? `DDRA_EV_PREA : t[cm];
  endfunction
  function automatic logic [3:0] bl(input logic [15:0] m, input logic a12);
    bl = m[1:0] == `DDRA_BL_OTF ? (a12 ? 4'h8 : 4'h4) : m[1:0] == `DDRA_BL_FIX4 ? 4'h4 : 4'h8;
  endfunction
  task go(input logic [1:0] cs, input logic [1:0] ck, input int r, input logic [2:0] cm, input logic [2:0] b,
          input logic [14:0] a);
    logic [2:0] ev;
    int         i;
    ev = (!cs[r] && ck[r]) ? ev_of(cm, a[10]) : `DDRA_EV_NONE;
    u_ddra_ctl_model.issue(cs, ck, cm, b, a);
    for (i = 0; i < 6 && ev_out[r*3+:3] === 3'h0; i++)
      @(negedge ref_clk);
    cmp(ev_out[r*3+:3], ev);
    if (ev == `DDRA_EV_ACT)
      cmp(row_out[r*15+:15], a);
    if (ev == `DDRA_EV_RD || ev == `DDRA_EV_WR)
    begin
      cmp(col_out[r*11+:11], x8_mode ? {1'b0, a[9:0]} : {a[11], a[9:0]});
      cmp(auto_precharge_addr_bit[r], a[10]);
      cmp(burst_length[r*4+:4], bl(mr_exp[r], a[12]));
    end
    if (ev inside {`DDRA_EV_ACT, `DDRA_EV_RD, `DDRA_EV_WR, `DDRA_EV_PRE})
      cmp(bank_out[r*3+:3], b);
    if (ev == `DDRA_EV_ACT)
      open_exp[r][b] = 1'b1;
    if (ev == `DDRA_EV_PRE || (ev inside {`DDRA_EV_RD, `DDRA_EV_WR} && a[10]))
      open_exp[r][b] = 1'b0;
    if (ev == `DDRA_EV_PREA)
      open_exp[r] = 8'h00;
    if (ev == `DDRA_EV_MRS && b == 3'h0)
      mr_exp[r] = {1'b0, a};
    cmp(open_banks[r*8+:8], open_exp[r]);
    cmp(mode_register_zero[r*16+:16], mr_exp[r]);
    cmp(termination_on, a[1:0]);
    // keep decoded commands seven cycles apart (eleven when nothing decodes), the slowest grade's access delay
    repeat (4) @(negedge ref_clk);
  endtask
  initial
  begin
    logic [1:0]  cs;
    logic [31:0] v;
    void'($urandom(32'h70565431));
    repeat (2) @(negedge ref_clk);
    reset_n = 1;
    for (int r = 0; r < 2; r++)
    begin
      cs = r ? 2'h1 : 2'h2;
      go(cs, 2'h3, r, `DDRA_CMD_MRS, 3'h0, 15'h0001);
      go(cs, 2'h3, r, `DDRA_CMD_MRS, 3'h1, 15'h0002);
      go(cs, 2'h3, r, `DDRA_CMD_ACT, 3'h5, 15'h7ABC);
      go(cs, 2'h3, r, `DDRA_CMD_ACT, 3'h2, 15'h0123);
      go(cs, 2'h3, r, `DDRA_CMD_RD, 3'h5, 15'h0BFF);
      x8_mode = 1;
      go(cs, 2'h3, r, `DDRA_CMD_WR, 3'h5, 15'h1FFF);
      x8_mode = 0;
      go(cs, 2'h3, r, `DDRA_CMD_PRE, 3'h2, 15'h0000);
      go(cs, 2'h3, r, `DDRA_CMD_ACT, 3'h7, 15'h0042);
      go(cs, 2'h3, r, `DDRA_CMD_PRE, 3'h0, 15'h0400);
      go(cs, 2'h3, r, `DDRA_CMD_REF, 3'h0, 15'h0000);
      go(2'h3, 2'h3, r, `DDRA_CMD_ACT, 3'h1, 15'h0000);
      go(cs, 2'h0, r, `DDRA_CMD_ACT, 3'h1, 15'h0000);
    end
    for (int n = 0; n < 60; n++)
    begin
      v = $urandom;
      x8_mode = v[1];
      cs = v[3:2] == 2'h0 ? 2'h3 : (v[0] ? 2'h1 : 2'h2);
      // close an open bank before opening a row in it again
      if (v[8:6] == `DDRA_CMD_ACT && open_exp[v[0]][v[11:9]])
        go(cs, 2'h3, int'(v[0]), `DDRA_CMD_PRE, v[11:9], 15'h0000);
      go(cs, v[5:4], int'(v[0]), v[8:6], v[11:9], v[26:12]);
    end
    end_sim;
  end
endmodule
bind ddra_top ddra_chk u_ddra_chk (.ref_clk, .reset_n, .cs_n_pin, .cke_pin, .ras_n_pin, .cas_n_pin, .we_n_pin,
  .ba_pin, .addr_pin, .x8_mode, .ev_out, .bank_out, .row_out, .col_out, .auto_precharge_addr_bit, .burst_length,
  .open_banks, .mode_register_zero, .termination_control, .termination_on);
